/* dv/angle_setup_and_field_alarms_tb.sv */
// Purpose: Self-checking bench for the angle setup block
// Assumes: Inputs change on the falling edge
// Notes:   Walks every alarm level code
`timescale 1ns/1ps
module angle_setup_and_field_alarms_tb;
  logic        ref_clk, rst, reg_wr, reg_rd, strong_alarm, weak_alarm;
  logic [7:0]  reg_addr, reg_wdata, reg_rdata, field_mt;
  logic [15:0] raw_angle, angle_out;
  logic [8:0]  gain_first, gain_second;
  int          n_errors = 0, samples_checked = 0;
  logic [7:0] sr[8] = '{8'h17,8'h22,8'h2F,8'h3A,8'h46,8'h51,8'h5C,8'h67};
  logic [7:0] sf[8] = '{8'h10,8'h1C,8'h28,8'h34,8'h3F,8'h4B,8'h56,8'h61};
  logic [7:0] wa[8] = '{8'h12,8'h1E,8'h2A,8'h36,8'h41,8'h4D,8'h58,8'h63};
  logic [7:0] wl[8] = '{8'h18,8'h24,8'h30,8'h3C,8'h47,8'h53,8'h5E,8'h69};
  angle_setup_and_field_alarms uut (.ref_clk, .rst, .reg_addr, .reg_wr,
    .reg_wdata, .reg_rd, .reg_rdata, .raw_angle, .field_mt, .angle_out,
    .gain_first, .gain_second, .strong_alarm, .weak_alarm);
  task automatic check(string nm, logic [15:0] seen, exp);
    samples_checked++;
    if (seen !== exp) begin
      n_errors++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic wr(logic [7:0] a, d);
    @(negedge ref_clk) {reg_addr, reg_wdata, reg_wr} = {a, d, 1'b1};
    @(negedge ref_clk) reg_wr = 1'b0;
  endtask
  task automatic rd(logic [7:0] a, exp);
    @(negedge ref_clk) {reg_addr, reg_rd} = {a, 1'b1};
    @(negedge ref_clk) reg_rd = 1'b0;
    check("reg_rdata", {8'h00, reg_rdata}, {8'h00, exp});
  endtask
  // Apply a field value, then check one alarm a cycle later
  task automatic fs(logic [7:0] v, logic w, exp);
    @(negedge ref_clk) field_mt = v;
    @(negedge ref_clk) check(w ? "weak_alarm" : "strong_alarm",
      {15'h0000, w ? weak_alarm : strong_alarm}, {15'h0000, exp});
  endtask
  task automatic give_verdict();
    if (n_errors == 0 && samples_checked > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  initial begin
    ref_clk = 1'b0;
    forever #2.5 ref_clk = ~ref_clk;
  end
  initial begin
    {rst, reg_wr, reg_rd, reg_addr, reg_wdata} = {3'b100, 16'h0000};
    {field_mt, raw_angle} = {8'h14, 16'h1234};
    repeat (3) @(negedge ref_clk);
    rst = 1'b0;
    @(negedge ref_clk);
    check("angle_out", angle_out, 16'h1234);
    check("gain_first", {7'h00, gain_first}, 16'h0100);
    check("gain_second", {7'h00, gain_second}, 16'h0100);
    rd(8'h02, 8'h01);
    rd(8'h05, 8'h00);
    wr(8'h06, 8'hFF);
    rd(8'h06, 8'h3F);
    for (int k = 0; k < 8; k++) begin
      wr(8'h06, {2'b00, 3'(k), 3'(k)});
      fs(sr[k] + 8'h01, 1'b0, 1'b1);
      fs(sf[k], 1'b0, 1'b1);
      fs(sf[k] - 8'h01, 1'b0, 1'b0);
      fs(wa[k] - 8'h01, 1'b1, 1'b1);
      fs(wl[k], 1'b1, 1'b1);
      fs(wl[k] + 8'h01, 1'b1, 1'b0);
    end
    wr(8'h00, 8'h10);
    wr(8'h03, 8'hAB);
    wr(8'h02, 8'h03);
    repeat (2) @(negedge ref_clk);
    check("angle_out", angle_out, 16'h1224);
    check("gain_first", {7'h00, gain_first}, 16'h00D5);
    check("gain_second", {7'h00, gain_second}, 16'h0100);
    wr(8'h02, 8'h04);
    raw_angle = 16'h0100;
    repeat (2) @(negedge ref_clk);
    check("angle_out", angle_out, 16'hFEF0);
    check("gain_first", {7'h00, gain_first}, 16'h0100);
    check("gain_second", {7'h00, gain_second}, 16'h00D5);
    rd(8'h03, 8'hAB);
    rd(8'h02, 8'h0C);
    wr(8'h03, 8'h80);
    repeat (2) @(negedge ref_clk);
    check("gain_second", {7'h00, gain_second}, 16'h00C0);
    give_verdict();
  end
endmodule

/* dv/angle_setup_asserts.sv */
// Purpose: Port-level checks for the angle setup block
// Assumes: Alarm levels span 16 to 105 mT over all codes
// Notes:   Bound to the design top
`timescale 1ns/1ps
module angle_setup_asserts (
  // Clock, reset, register port and field strength
  input wire logic        ref_clk, rst, reg_wr, reg_rd,
  input wire logic [7:0]  reg_addr, reg_wdata, reg_rdata, field_mt,
  // Angle, trims and alarms
  input wire logic [15:0] raw_angle, angle_out,
  input wire logic [8:0]  gain_first, gain_second,
  input wire logic        strong_alarm, weak_alarm
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  logic touched;
  always_ff @(posedge ref_clk) touched <= !rst && (touched || reg_wr);
  sequence cut_first_wr;
    reg_wr && reg_addr == 8'h02 && reg_wdata[2:1] == 2'b01 ##1 !reg_wr;
  endsequence
  sequence levels_wr_rd;
    reg_wr && reg_addr == 8'h06 ##1 !reg_wr ##1 reg_rd && reg_addr == 8'h06;
  endsequence
  sense_default_a: assert property (
    !touched |=> angle_out == $past(raw_angle)) else $error("angle off");
  cut_first_a: assert property (cut_first_wr |=>
    gain_second == 9'h100 && gain_first < 9'h100) else $error("gain off");
  levels_readback_a: assert property (levels_wr_rd |=>
    reg_rdata[5:0] == $past(reg_wdata[5:0], 3)) else $error("levels off");
  levels_reserved_a: assert property (reg_rd && reg_addr == 8'h06 |=>
    reg_rdata[7:6] == 2'b00) else $error("levels top bits set");
  unmapped_read_a: assert property (reg_rd && reg_addr == 8'h05 |=>
    reg_rdata == 8'h00) else $error("unmapped read not zero");
  strong_set_a: assert property (
    field_mt > 8'h67 |=> strong_alarm) else $error("strong not set");
  strong_clear_a: assert property (
    field_mt < 8'h10 |=> !strong_alarm) else $error("strong not clear");
  weak_set_a: assert property (
    field_mt < 8'h12 |=> weak_alarm) else $error("weak not set");
  weak_clear_a: assert property (
    field_mt > 8'h69 |=> !weak_alarm) else $error("weak not clear");
endmodule
bind angle_setup_and_field_alarms angle_setup_asserts chk (.ref_clk, .rst,
  .reg_addr, .reg_wr, .reg_wdata, .reg_rd, .reg_rdata, .raw_angle,
  .field_mt, .angle_out, .gain_first, .gain_second, .strong_alarm,
  .weak_alarm);

/* hdl/angle_setup_and_field_alarms.sv */
// Purpose: Rotation sense, angle origin, axis trims and field alarms
// Assumes: Raw angle and field strength arrive sampled on ref_clk
// Notes:   Register reads return data one cycle after reg_rd
//
// Contract
// - Sense resets to 1, counting up for clockwise; 0 reverses it.
// - A 16-bit origin is subtracted from every reported angle.
// - Strong alarm sets above the rising level, clears below falling.
// - Weak alarm sets below the lower level, clears above the upper.
// - Both 3-bit level selects sit in the 8-bit register at 0x06.
// - Strong levels rise 23..103 mT and fall 16..97 mT by code.
// - Weak levels assert below 18..99 mT and release above 24..105.
// - Both axes default to gain 256; one attenuate bit alone cuts its axis, both set cut none.
// - An 8-bit reduction value sets the cut axis gain, higher is more.
`timescale 1ns/1ps
`include "angle_setup_consts.svh"

// Picks one level out of a packed table of eight
module level_pick #(
  parameter int                 WIDTH = 8,
  parameter logic [8*WIDTH-1:0] TABLE = '0
) (
  // Level code
  input  wire logic [2:0]       sel,
  // Chosen level
  output logic      [WIDTH-1:0] level
);

  always_comb begin
    level = TABLE[sel*WIDTH +: WIDTH];
  end

endmodule

// Two-level hysteretic compare; between the levels the flag holds
module band_flag #(
  parameter int WIDTH     = 8,
  parameter bit SET_ABOVE = 1'b1
) (
  // Field and the two levels in force this cycle
  input  wire logic [WIDTH-1:0] field,
  input  wire logic [WIDTH-1:0] set_level,
  input  wire logic [WIDTH-1:0] clear_level,
  // Flag as registered now, and its next value
  input  wire logic             flag,
  output logic                  next_flag
);

  logic set_hit;
  logic clear_hit;

  always_comb begin
    // Strict compares: a field equal to a level is inside the band
    if (SET_ABOVE) begin
      set_hit   = field > set_level;
      clear_hit = field < clear_level;
    end else begin
      set_hit   = field < set_level;
      clear_hit = field > clear_level;
    end
    if (set_hit) begin
      next_flag = 1'b1;
    end else if (clear_hit) begin
      next_flag = 1'b0;
    end else begin
      next_flag = flag;
    end
  end

endmodule

module angle_setup_and_field_alarms (
  // Clock and reset
  input  wire logic        ref_clk,
  input  wire logic        rst,
  // Register port
  input  wire logic [7:0]  reg_addr,
  input  wire logic        reg_wr,
  input  wire logic [7:0]  reg_wdata,
  input  wire logic        reg_rd,
  output logic      [7:0]  reg_rdata,
  // Sensor inputs
  input  wire logic [15:0] raw_angle,
  input  wire logic [7:0]  field_mt,
  // Angle and trim outputs
  output logic      [15:0] angle_out,
  output logic      [8:0]  gain_first,
  output logic      [8:0]  gain_second,
  // Alarm pins
  output logic             strong_alarm,
  output logic             weak_alarm
);

  localparam logic [63:0] STRONG_RISE  = `STRONG_RISE_TABLE;
  localparam logic [63:0] STRONG_FALL  = `STRONG_FALL_TABLE;
  localparam logic [63:0] WEAK_ASSERT  = `WEAK_ASSERT_TABLE;
  localparam logic [63:0] WEAK_RELEASE = `WEAK_RELEASE_TABLE;

  angle_setup_pkg::state_s cur;
  angle_setup_pkg::state_s next_cur;

  logic [2:0]  strong_sel;
  logic [2:0]  weak_sel;
  logic [7:0]  strong_rise;
  logic [7:0]  strong_fall;
  logic [7:0]  weak_assert;
  logic [7:0]  weak_release;
  logic [15:0] sensed;
  logic [8:0]  cut_gain;
  logic        strong_next;
  logic        weak_next;

  // Level selects straight from the stored register
  assign strong_sel = cur.field_alarm_levels[`STRONG_SEL_MSB:`STRONG_SEL_LSB];
  assign weak_sel   = cur.field_alarm_levels[`WEAK_SEL_MSB:`WEAK_SEL_LSB];

  // Level lookup from the stored selects
  level_pick #(.WIDTH(8), .TABLE(STRONG_RISE)) pick_strong_rise (
    .sel   (strong_sel),
    .level (strong_rise)
  );

  level_pick #(.WIDTH(8), .TABLE(STRONG_FALL)) pick_strong_fall (
    .sel   (strong_sel),
    .level (strong_fall)
  );

  level_pick #(.WIDTH(8), .TABLE(WEAK_ASSERT)) pick_weak_assert (
    .sel   (weak_sel),
    .level (weak_assert)
  );

  level_pick #(.WIDTH(8), .TABLE(WEAK_RELEASE)) pick_weak_release (
    .sel   (weak_sel),
    .level (weak_release)
  );

  // Hysteretic compares, strong sets above and weak sets below
  band_flag #(.WIDTH(8), .SET_ABOVE(1'b1)) strong_band (
    .field       (field_mt),
    .set_level   (strong_rise),
    .clear_level (strong_fall),
    .flag        (cur.strong_alarm),
    .next_flag   (strong_next)
  );

  band_flag #(.WIDTH(8), .SET_ABOVE(1'b0)) weak_band (
    .field       (field_mt),
    .set_level   (weak_assert),
    .clear_level (weak_release),
    .flag        (cur.weak_alarm),
    .next_flag   (weak_next)
  );

  always_comb begin
    next_cur = cur;
    // Register writes
    if (reg_wr) begin
      unique case (reg_addr)
        `ADDR_ORIGIN_LO:    next_cur.origin[7:0] = reg_wdata;
        `ADDR_ORIGIN_HI:    next_cur.origin[15:8] = reg_wdata;
        `ADDR_SENSE_TRIM: begin
          next_cur.sense        = reg_wdata[`SENSE_BIT];
          next_cur.atten_first  = reg_wdata[`ATTEN_FIRST_BIT];
          next_cur.atten_second = reg_wdata[`ATTEN_SECOND_BIT];
        end
        `ADDR_SENS_REDUCE:  next_cur.sensitivity_reduction = reg_wdata;
        `ADDR_ALARM_LEVELS: begin
          next_cur.field_alarm_levels = {2'b00, reg_wdata[5:0]};
        end
        default: ;
      endcase
    end
    // Register reads
    if (reg_rd) begin
      unique case (reg_addr)
        `ADDR_ORIGIN_LO:    next_cur.rd_data = cur.origin[7:0];
        `ADDR_ORIGIN_HI:    next_cur.rd_data = cur.origin[15:8];
        `ADDR_SENSE_TRIM:   next_cur.rd_data = {3'h0, cur.weak_alarm,
                              cur.strong_alarm, cur.atten_second,
                              cur.atten_first, cur.sense};
        `ADDR_SENS_REDUCE:  next_cur.rd_data = cur.sensitivity_reduction;
        `ADDR_ALARM_LEVELS: next_cur.rd_data = cur.field_alarm_levels;
        default:            next_cur.rd_data = 8'h00;
      endcase
    end

    // Inside the band the pin holds
    next_cur.strong_alarm = strong_next;
    next_cur.weak_alarm   = weak_next;

    // Sense then origin: clockwise counts up while sense is 1
    sensed = cur.sense ? raw_angle : 16'(16'h0000 - raw_angle);
    next_cur.angle_out = 16'(sensed - cur.origin);

    // Cut axis gain: reduction 255 is nearly full, 0 is half
    cut_gain = 9'(9'h080 + {2'b00, cur.sensitivity_reduction[7:1]});
    next_cur.gain_first  = (cur.atten_first && !cur.atten_second) ?
                           cut_gain : `FULL_GAIN;
    next_cur.gain_second = (cur.atten_second && !cur.atten_first) ?
                           cut_gain : `FULL_GAIN;
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      cur                    <= '0;
      cur.sense              <= `SENSE_RESET;
      cur.field_alarm_levels <= `ALARM_LEVELS_RESET;
      cur.gain_first         <= `FULL_GAIN;
      cur.gain_second        <= `FULL_GAIN;
    end else begin
      cur <= next_cur;
    end
  end

  assign reg_rdata    = cur.rd_data;
  assign angle_out    = cur.angle_out;
  assign gain_first   = cur.gain_first;
  assign gain_second  = cur.gain_second;
  assign strong_alarm = cur.strong_alarm;
  assign weak_alarm   = cur.weak_alarm;

endmodule

/* hdl/angle_setup_consts.svh */
// Purpose: Offsets, field positions, reset values and level tables
// Assumes: Field strengths carried in whole mT
// Notes:   Register port is an 8-bit address / 8-bit data port
`ifndef ANGLE_SETUP_CONSTS_SVH
`define ANGLE_SETUP_CONSTS_SVH
`define ADDR_ORIGIN_LO     8'h00
`define ADDR_ORIGIN_HI     8'h01
`define ADDR_SENSE_TRIM    8'h02
`define ADDR_SENS_REDUCE   8'h03
`define ADDR_ALARM_LEVELS  8'h06
`define STRONG_SEL_MSB     5
`define STRONG_SEL_LSB     3
`define WEAK_SEL_MSB       2
`define WEAK_SEL_LSB       0
`define SENSE_BIT          0
`define ATTEN_FIRST_BIT    1
`define ATTEN_SECOND_BIT   2
`define SENSE_RESET        1'b1
`define ALARM_LEVELS_RESET 8'h00
`define FULL_GAIN          9'h100
`define STRONG_RISE_TABLE  {8'd103, 8'd92, 8'd81, 8'd70, 8'd58, 8'd47, \
                            8'd34, 8'd23}
`define STRONG_FALL_TABLE  {8'd97, 8'd86, 8'd75, 8'd63, 8'd52, 8'd40, \
                            8'd28, 8'd16}
`define WEAK_ASSERT_TABLE  {8'd99, 8'd88, 8'd77, 8'd65, 8'd54, 8'd42, \
                            8'd30, 8'd18}
`define WEAK_RELEASE_TABLE {8'd105, 8'd94, 8'd83, 8'd71, 8'd60, 8'd48, \
                            8'd36, 8'd24}
`endif

/* hdl/angle_setup_pkg.sv */
// Purpose: Types shared by the angle setup block
// Assumes: Nothing
// Notes:   Constants live in angle_setup_consts.svh
package angle_setup_pkg;
  typedef struct packed {
    logic [15:0] origin;
    logic        sense;
    logic        atten_first;
    logic        atten_second;
    logic [7:0]  sensitivity_reduction;
    logic [7:0]  field_alarm_levels;
    logic        strong_alarm;
    logic        weak_alarm;
    logic [7:0]  rd_data;
    logic [15:0] angle_out;
    logic [8:0]  gain_first;
    logic [8:0]  gain_second;
  } state_s;
endpackage
